// file: rtl/psc_sideband_ctl.sv
// Sideband control of a bus agent: arbitration, interrupt, reset, power and parity error reporting.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Assert the bus request toward the arbiter while mastership is needed.
// - Start a master transaction only after the grant is seen asserted.
// - Interrupt output is active low and held as a level while the condition lasts.
// - All bus inputs except interrupt and reset are sampled on the rising clock edge.
// - While bus reset is asserted, float every bus output and ignore every input.
// - Internal state is reset and leaves reset on the rising edge of bus reset; the code leaves it on the first clock edge after release.
// - Report an address parity error by driving system error low for one clock.
// - Report data parity errors for every transaction except Special Cycle.
// - Drive parity error low two clocks after a data parity error is detected.
// - Hold parity error low at least one clock per erroneous data phase.
// - While power good is low, stay in reset and float every bus signal.
// - With auxiliary power present, report D3cold as supported.
// - Parity is even across the address/data and command/byte-enable lines.
// - A data phase completes when initiator ready and target ready are both asserted.
module psc_sideband_ctl
  import psc_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             bus_rst_n_i,
  input  wire logic             power_good_in_i,
  input  wire logic             aux_power_present_i,
  input  wire logic             m66_en_i,
  input  wire logic             gnt_n_i,
  input  wire logic             irdy_n_i,
  input  wire logic             trdy_n_i,
  input  wire logic [AD_W-1:0]  ad_i,
  input  wire logic [CBE_W-1:0] cbe_n_i,
  input  wire logic             par_i,
  input  wire logic             addr_chk_i,
  input  wire logic             data_rx_i,
  input  wire logic             master_req_i,
  input  wire logic             irq_cond_i,
  output logic                  master_go_o,
  output logic                  bus_66mhz_o,
  output logic                  d3cold_ok_o,
  output logic                  req_n_o,
  output logic                  req_n_oe_n_o,
  output logic                  inta_n_o,
  output logic                  inta_n_oe_n_o,
  output logic                  serr_n_o,
  output logic                  serr_n_oe_n_o,
  output logic                  perr_n_o,
  output logic                  perr_n_oe_n_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // State and parity checker.

  psc_state_s st_ff;
  psc_state_s nxt_st;
  logic       in_rst;
  logic       live;
  logic       data_done;

  psc_par_if pi ();

  psc_parity_chk i_psc_parity_chk (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pi      (pi)
  );

  // Bus reset and missing power good are treated alike so that one term floats the pins.
  assign in_rst    = ~bus_rst_n_i | ~power_good_in_i;
  assign live      = ~in_rst;
  assign data_done = ~irdy_n_i & ~trdy_n_i;

  // Only the check strobes are gated by the reset term, so nothing on the bus is checked during reset.
  assign pi.ad       = ad_i;
  assign pi.cbe_n    = cbe_n_i;
  assign pi.par      = par_i;
  assign pi.addr_chk = addr_chk_i & live;
  assign pi.data_chk = data_rx_i & data_done & ~st_ff.special & live;

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode.

  // The command field is active low on the pins, so the code is compared as it arrives.
  function automatic logic cmd_is_special(input logic [CBE_W-1:0] cmd);
    return (cmd == CMD_SPECIAL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.req       = master_req_i;
    nxt_st.gnt       = ~gnt_n_i;
    nxt_st.inta      = irq_cond_i;
    nxt_st.m66       = m66_en_i;
    nxt_st.aux       = aux_power_present_i;
    nxt_st.serr      = pi.ape;
    nxt_st.perr_pend = pi.dpe;
    if (addr_chk_i) begin
      nxt_st.special = cmd_is_special(cbe_n_i);
    end
    case (st_ff.perr_st)
      PERR_IDLE: begin
        if (st_ff.perr_pend) begin
          nxt_st.perr_st = PERR_ACT;
        end
      end
      PERR_ACT: begin
        if (!st_ff.perr_pend) begin
          nxt_st.perr_st = PERR_HI;
        end
      end
      PERR_HI: begin
        if (st_ff.perr_pend) begin
          nxt_st.perr_st = PERR_ACT;
        end else begin
          nxt_st.perr_st = PERR_IDLE;
        end
      end
      default: begin
        nxt_st.perr_st = PERR_IDLE;
      end
    endcase
    // Held in reset while bus reset or power good is low, so state leaves reset on the first clock edge after release.
    if (in_rst) begin
      nxt_st = PSC_ST_RST;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= PSC_ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin outputs.

  // The enables include the reset term directly so the pins float in the very cycle reset arrives.
  assign master_go_o   = st_ff.req & st_ff.gnt & live;
  assign bus_66mhz_o   = st_ff.m66;
  assign d3cold_ok_o   = st_ff.aux;
  assign req_n_o       = ~st_ff.req;
  assign req_n_oe_n_o  = in_rst;
  assign inta_n_o      = ~st_ff.inta;
  assign inta_n_oe_n_o = ~st_ff.inta | in_rst;
  assign serr_n_o      = ~st_ff.serr;
  assign serr_n_oe_n_o = ~st_ff.serr | in_rst;
  assign perr_n_o      = (st_ff.perr_st != PERR_ACT);
  assign perr_n_oe_n_o = (st_ff.perr_st == PERR_IDLE) | in_rst;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  default clocking cb @(posedge clk_i);
  endclocking

  default disable iff (!rst_n_i);

  AST_REQ: assert property (
    (master_req_i && live) ##1 live |-> !req_n_o && !req_n_oe_n_o)
    else $error("Bus request not asserted after mastership was needed.");

  AST_GNT_FIRST: assert property (
    master_go_o |-> !$past(gnt_n_i) && $past(master_req_i))
    else $error("Master start without a sampled grant.");

  AST_INTA_LEVEL: assert property (
    (irq_cond_i && live)[*3] ##1 live |-> !inta_n_o && !inta_n_oe_n_o)
    else $error("Interrupt output not held while its condition lasts.");

  AST_FLOAT_RST: assert property (
    !bus_rst_n_i |-> req_n_oe_n_o && inta_n_oe_n_o && serr_n_oe_n_o && perr_n_oe_n_o)
    else $error("A bus output is driven during bus reset.");

  AST_FLOAT_PG: assert property (
    !power_good_in_i |-> req_n_oe_n_o && inta_n_oe_n_o && serr_n_oe_n_o && !master_go_o)
    else $error("A bus output is driven while power good is low.");

  AST_RST_RELEASE: assert property (
    $rose(bus_rst_n_i) && power_good_in_i |-> st_ff == PSC_ST_RST)
    else $error("State not at reset value when bus reset is released.");

  AST_SERR_ONE: assert property (
    (pi.ape && live) ##1 (live && !pi.ape) |-> !serr_n_o && !serr_n_oe_n_o ##1 serr_n_oe_n_o)
    else $error("System error not driven for exactly one clock.");

  AST_NO_SPECIAL: assert property (
    st_ff.special |-> !pi.data_chk)
    else $error("Data parity checked during a Special Cycle.");

  AST_PERR_TWO: assert property (
    (pi.dpe && live) ##1 live ##1 live |-> !perr_n_o && !perr_n_oe_n_o)
    else $error("Parity error not driven two clocks after detection.");

  AST_PERR_EACH: assert property (
    (pi.dpe && live) ##1 (pi.dpe && live) ##1 live ##1 live |-> !perr_n_o && !$past(perr_n_o))
    else $error("Parity error not held for each erroneous data phase.");

  AST_PERR_REL: assert property (
    (st_ff.perr_st == PERR_ACT) && !st_ff.perr_pend && !pi.dpe && live ##1 live
      |-> perr_n_o && !perr_n_oe_n_o ##1 (perr_n_oe_n_o || in_rst))
    else $error("Parity error released without one driven high clock.");

  AST_AUX: assert property (
    (aux_power_present_i && live) ##1 live |-> d3cold_ok_o)
    else $error("D3cold support not reported with auxiliary power present.");

  // The checks below watch the quiet side of each pin, where a stuck driver would go unseen.

  AST_REQ_DROP: assert property (
    !master_req_i |=> req_n_o)
    else $error("Bus request still asserted after mastership was given up.");

  AST_GO_NEEDS_REQ: assert property (
    master_go_o |-> !req_n_o && !req_n_oe_n_o)
    else $error("Master start without a driven bus request.");

  AST_NO_GRANT_NO_GO: assert property (
    $past(gnt_n_i) |-> !master_go_o)
    else $error("Master start although no grant was sampled.");

  AST_INTA_DROP: assert property (
    !irq_cond_i |=> inta_n_oe_n_o)
    else $error("Interrupt output still driven after its condition ended.");

  AST_INTA_ONLY_LOW: assert property (
    !inta_n_oe_n_o |-> !inta_n_o)
    else $error("Interrupt output driven high.");

  AST_ADDR_IGNORED: assert property (
    in_rst |=> !pi.ape)
    else $error("Address phase checked during reset.");

  AST_GO_FLOAT: assert property (
    in_rst |-> !master_go_o)
    else $error("Master start during reset.");

  AST_HOLD_RST: assert property (
    in_rst |=> st_ff == PSC_ST_RST)
    else $error("State not held at its reset value during reset.");

  AST_PERR_FLOAT_PG: assert property (
    !power_good_in_i |-> perr_n_oe_n_o)
    else $error("Parity error driven while power good is low.");

  AST_SPEED: assert property (
    live |=> bus_66mhz_o == $past(m66_en_i))
    else $error("Bus speed indication does not follow the enable input.");

  AST_D3_OFF: assert property (
    !aux_power_present_i |=> !d3cold_ok_o)
    else $error("D3cold support reported without auxiliary power.");

  AST_SERR_ONLY_LOW: assert property (
    !serr_n_oe_n_o |-> !serr_n_o)
    else $error("System error driven high.");

  AST_SERR_CAUSE: assert property (
    !serr_n_oe_n_o |-> $past(pi.ape))
    else $error("System error driven without an address parity error.");

  AST_DPE_NOT_SERR: assert property (
    pi.dpe && !pi.ape |=> serr_n_oe_n_o)
    else $error("Data parity error reported on the system error line.");

  AST_SPECIAL_SET: assert property (
    addr_chk_i && live && (cbe_n_i == CMD_SPECIAL) |=> st_ff.special)
    else $error("Special Cycle command not remembered.");

  AST_SPECIAL_CLR: assert property (
    addr_chk_i && live && (cbe_n_i != CMD_SPECIAL) |=> !st_ff.special)
    else $error("Special Cycle status kept after another command.");

  AST_DATA_CHECKED: assert property (
    live && data_rx_i && !irdy_n_i && !trdy_n_i && !st_ff.special |-> pi.data_chk)
    else $error("Completed data phase not checked for parity.");

  AST_WAIT_NOT_CHECKED: assert property (
    irdy_n_i || trdy_n_i |-> !pi.data_chk)
    else $error("Parity checked in a wait cycle.");

  AST_PERR_CAUSE: assert property (
    !perr_n_o |-> $past(pi.dpe, 2))
    else $error("Parity error driven low without a detection two clocks before.");

  AST_PERR_LOW_DRIVEN: assert property (
    !perr_n_o && live |-> !perr_n_oe_n_o)
    else $error("Parity error low but not driven.");

  AST_PERR_HIGH_ONE: assert property (
    perr_n_o && !perr_n_oe_n_o |-> !$past(perr_n_o))
    else $error("Parity error driven high without a low clock before it.");

  AST_PERR_HI_ENDS: assert property (
    perr_n_o && !perr_n_oe_n_o |=> !perr_n_o || perr_n_oe_n_o)
    else $error("Parity error driven high for more than one clock.");

  COV_MASTER: cover property (master_req_i ##[1:4] master_go_o);
  COV_SERR: cover property (!serr_n_o && !serr_n_oe_n_o);
  COV_PERR_BURST: cover property (pi.dpe [*2] ##2 !perr_n_o ##1 !perr_n_o);
  COV_INTA: cover property (!inta_n_o ##1 inta_n_oe_n_o);
  COV_SPECIAL_QUIET: cover property (st_ff.special && data_rx_i && !irdy_n_i && !trdy_n_i);

endmodule
`default_nettype wire

// file: rtl/psc_pkg.sv
// Package with the constants, state types and reset values of the sideband control block.
package psc_pkg;

  // Bus clock figures; all bus timing counts whole clocks of this period.
  localparam int unsigned CLK_PERIOD_PS = 4000;

  // Command code on the command/byte-enable lines that marks a Special Cycle.
  localparam logic [3:0]  CMD_SPECIAL   = 4'h1;

  // Widths of the multiplexed address/data and command/byte-enable lines.
  localparam int unsigned AD_W          = 32;
  localparam int unsigned CBE_W         = 4;

  typedef enum logic [1:0] {
    PERR_IDLE = 2'b00,
    PERR_ACT  = 2'b01,
    PERR_HI   = 2'b10
  } psc_perr_e;

  typedef struct packed {
    logic      req;
    logic      gnt;
    logic      inta;
    logic      m66;
    logic      aux;
    logic      special;
    logic      serr;
    logic      perr_pend;
    psc_perr_e perr_st;
  } psc_state_s;

  typedef struct packed {
    logic [AD_W-1:0]  ad;
    logic [CBE_W-1:0] cbe_n;
    logic             a_chk;
    logic             d_chk;
  } psc_chk_s;

  localparam psc_state_s PSC_ST_RST  = '{default: '0, perr_st: PERR_IDLE};
  localparam psc_chk_s   PSC_CHK_RST = '0;

endpackage

// file: rtl/psc_par_if.sv
// Interface between the sideband controller and its parity checker.
`timescale 1ns/1ps
`default_nettype none
interface psc_par_if;
  import psc_pkg::*;
  logic [AD_W-1:0]  ad;
  logic [CBE_W-1:0] cbe_n;
  logic             par;
  logic             addr_chk;
  logic             data_chk;
  logic             ape;
  logic             dpe;

  modport chk (
    input  ad,
    input  cbe_n,
    input  par,
    input  addr_chk,
    input  data_chk,
    output ape,
    output dpe
  );

  modport ctl (
    output ad,
    output cbe_n,
    output par,
    output addr_chk,
    output data_chk,
    input  ape,
    input  dpe
  );
endinterface
`default_nettype wire

// file: rtl/psc_parity_chk.sv
// Even parity checker for address and data phases.
`timescale 1ns/1ps
`default_nettype none
module psc_parity_chk
  import psc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  psc_par_if.chk    pi
);

  psc_chk_s st_ff;
  psc_chk_s nxt_st;
  logic     exp_par;

  // The lines are held one clock because parity arrives one clock after them.
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.ad    = pi.ad;
    nxt_st.cbe_n = pi.cbe_n;
    nxt_st.a_chk = pi.addr_chk;
    nxt_st.d_chk = pi.data_chk;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= PSC_CHK_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign exp_par = ^{st_ff.ad, st_ff.cbe_n};
  assign pi.ape  = st_ff.a_chk & (pi.par != exp_par);
  assign pi.dpe  = st_ff.d_chk & (pi.par != exp_par);

  AST_EVEN_PAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_ff.d_chk && (^{$past(pi.ad), $past(pi.cbe_n), pi.par}) |-> pi.dpe)
    else $error("Odd parity on a checked data phase was not flagged.");

  AST_PAR_OK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(^{$past(pi.ad), $past(pi.cbe_n), pi.par}) |-> !pi.ape && !pi.dpe)
    else $error("Parity error flagged although parity was even.");

endmodule
`default_nettype wire

// file: bench/psc_arb_model.sv
// Arbiter model that grants the bus a chosen number of clocks after a request.
`timescale 1ns/1ps
`default_nettype none
module psc_arb_model (
  input  wire logic       clk_i,
  input  wire logic       req_n_i,
  input  wire logic       req_oe_n_i,
  input  wire logic [1:0] lat_i,
  output logic            gnt_n_o
);
  logic [1:0] cnt;
  // A floating request reads as none, as the pull-up on the line would make it.
  wire req = !req_n_i && !req_oe_n_i;
  always @(posedge clk_i) begin
    cnt <= !req ? 2'h0 : (cnt != lat_i ? cnt + 2'h1 : cnt);
    gnt_n_o <= !(req && cnt == lat_i);
  end
endmodule
`default_nettype wire

// file: bench/pci_sideband_control_bench.sv
// Self-checking bench of the sideband control block.
`timescale 1ns/1ps
`default_nettype none
module pci_sideband_control_bench;
  import psc_pkg::*;
  logic clk_i = 0, rst_n_i = 0, brst_n = 1, pg = 1, aux = 0, m66 = 0, mreq = 0, irq = 0;
  logic irdy_n = 1, trdy_n = 1, par = 0, addr_chk = 0, data_rx = 0;
  logic [31:0] ad = 32'h0;
  logic [3:0] cbe_n = 4'hf;
  logic [1:0] lat = 2'h0;
  logic gnt_n, go, b66, d3c, req_n, req_oe, inta_n, inta_oe, serr_n, serr_oe, perr_n, perr_oe;
  int error_cnt = 0, comparisons = 0, cycles = 0;

  psc_sideband_ctl i_psc_sideband_ctl (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_rst_n_i(brst_n),
    .power_good_in_i(pg), .aux_power_present_i(aux), .m66_en_i(m66), .gnt_n_i(gnt_n),
    .irdy_n_i(irdy_n), .trdy_n_i(trdy_n), .ad_i(ad), .cbe_n_i(cbe_n), .par_i(par),
    .addr_chk_i(addr_chk), .data_rx_i(data_rx), .master_req_i(mreq), .irq_cond_i(irq),
    .master_go_o(go), .bus_66mhz_o(b66), .d3cold_ok_o(d3c), .req_n_o(req_n), .req_n_oe_n_o(req_oe),
    .inta_n_o(inta_n), .inta_n_oe_n_o(inta_oe), .serr_n_o(serr_n), .serr_n_oe_n_o(serr_oe),
    .perr_n_o(perr_n), .perr_n_oe_n_o(perr_oe));
  psc_arb_model i_psc_arb_model (.clk_i(clk_i), .req_n_i(req_n), .req_oe_n_i(req_oe), .lat_i(lat),
    .gnt_n_o(gnt_n));

  initial forever #2 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // The run needs well under a thousand clocks, so this ceiling only trips on a hang.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_opts;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      m66 <= i[0];
      aux <= i[1];
      @(posedge clk_i);
      #1;
      chk(b66 === i[0] && d3c === i[1], "speed or aux flag");
    end
  endtask
  task automatic t_arb(input logic [1:0] l);
    logic g;
    @(posedge clk_i);
    lat <= l;
    mreq <= 1'b1;
    @(posedge clk_i);
    #1;
    chk(req_n === 1'b0 && req_oe === 1'b0, "request not driven");
    repeat (6) begin
      @(posedge clk_i);
      g = gnt_n;
      #1;
      chk(go === !g, "start does not follow grant");
    end
    @(posedge clk_i);
    mreq <= 1'b0;
    @(posedge clk_i);
    #1;
    chk(req_n === 1'b1 && go === 1'b0, "request not withdrawn");
  endtask
  task automatic t_irq;
    @(posedge clk_i);
    irq <= 1'b1;
    repeat (5) begin
      @(posedge clk_i);
      #1;
      chk(inta_n === 1'b0 && inta_oe === 1'b0, "interrupt level lost");
    end
    @(posedge clk_i);
    irq <= 1'b0;
    @(posedge clk_i);
    #1;
    chk(inta_oe === 1'b1, "interrupt not released");
  endtask
  task automatic t_addr(input logic [3:0] c, input bit bad);
    @(posedge clk_i);
    addr_chk <= 1'b1;
    ad <= 32'h5a0f_3c01 ^ {28'h0, c};
    cbe_n <= c;
    @(posedge clk_i);
    addr_chk <= 1'b0;
    par <= ^{ad, cbe_n} ^ bad;
    @(posedge clk_i);
    #1;
    chk(serr_oe === !bad && serr_n === !bad, "address error report");
    @(posedge clk_i);
    #1;
    chk(serr_oe === 1'b1, "system error held too long");
  endtask
  // Expects silence when the phase is a special cycle or the initiator is waiting.
  task automatic t_data(input int n, input bit quiet, input bit w);
    @(posedge clk_i);
    data_rx <= 1'b1;
    irdy_n <= w;
    trdy_n <= 1'b0;
    for (int k = 1; k < 8; k++) begin
      @(posedge clk_i);
      par <= (k <= n) ? !(^{ad, cbe_n}) : ^{ad, cbe_n};
      if (k == n) begin
        data_rx <= 1'b0;
        irdy_n <= 1'b1;
        trdy_n <= 1'b1;
      end
      #1;
      if (quiet)
        chk(perr_oe === 1'b1, "parity error not suppressed");
      else if (k >= 3 && k <= n + 3)
        chk(perr_oe === 1'b0 && perr_n === (k == n + 3), "data error drive");
      else
        chk(perr_oe === 1'b1, "parity error line not floated");
    end
  endtask
  task automatic t_rst(input bit pwr);
    @(posedge clk_i);
    mreq <= 1'b1;
    irq <= 1'b1;
    repeat (2) @(posedge clk_i);
    if (pwr) pg <= 1'b0;
    else brst_n <= 1'b0;
    #1;
    chk({req_oe, inta_oe, serr_oe, perr_oe, go} === 5'h1e, "pins not floated");
    repeat (3) @(posedge clk_i);
    pg <= 1'b1;
    brst_n <= 1'b1;
    #1;
    chk(req_n === 1'b1 && req_oe === 1'b0 && inta_oe === 1'b1, "state not cleared");
    @(posedge clk_i);
    mreq <= 1'b0;
    irq <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_opts();
    t_arb(2'h0);
    t_arb(2'h3);
    t_irq();
    t_addr(4'h7, 1'b1);
    t_addr(4'h6, 1'b0);
    t_data(1, 1'b0, 1'b0);
    t_data(2, 1'b0, 1'b0);
    t_data(1, 1'b1, 1'b1);
    t_addr(CMD_SPECIAL, 1'b0);
    t_data(1, 1'b1, 1'b0);
    t_addr(4'h6, 1'b0);
    t_data(1, 1'b0, 1'b0);
    t_rst(1'b0);
    t_rst(1'b1);
    conclude();
  end
endmodule
`default_nettype wire
